/* pldm_regs.svh */
// constants of the loop divider and lock monitor
// assumes: included by bare name from the divider and top modules
`ifndef PLDM_REGS_SVH
`define PLDM_REGS_SVH

// ------------------------------------------------------------
// lock detector window and tolerances, in clock edges
// ------------------------------------------------------------
`define PLDM_LOCK_WINDOW 8'h10
`define PLDM_ACQUIRE_TOL 8'h01
`define PLDM_RELEASE_TOL 8'h03

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define PLDM_RATIO_RST 8'h01
`define PLDM_COUNT_RST 8'h00
`define PLDM_BW_RST 4'h0

`endif

/* pldm_pkg.sv */
// types shared by the loop divider and lock monitor
// assumes: nothing beyond the compiler
package pldm_pkg;
    typedef logic [7:0] pldm_ratio_t;
    typedef enum logic [0:0] {
        PLDM_UNLOCKED = 1'b0,
        PLDM_LOCKED = 1'b1
    } pldm_lock_e;
endpackage

/* pldm_div_if.sv */
// control and result of one edge-counting clock divider
// assumes: all signals on the system clock
`timescale 1ns/1ps
`default_nettype none
interface pldm_div_if;
    logic edge_p;
    logic level;
    pldm_pkg::pldm_ratio_t ratio;
    logic clk_o;
    logic rise_p;
    modport ctl (output edge_p, output level, output ratio, input clk_o, input rise_p);
    modport div (input edge_p, input level, input ratio, output clk_o, output rise_p);
endinterface
`default_nettype wire

/* pldm_div.sv */
// edge-counting divider: one output period per ratio input periods
// assumes: edge_p is a one-cycle pulse per rising input edge, all synchronous
`timescale 1ns/1ps
`default_nettype none
`include "pldm_regs.svh"
module pldm_div (
    input wire logic clk,
    input wire logic rst_n,
    pldm_div_if.div d
);
    logic [7:0] cnt_q;
    logic [7:0] cnt_d;
    logic out_q;
    logic out_d;
    logic rise_q;

    // ------------------------------------------------------------
    // counter and output phase
    // ------------------------------------------------------------
    always_comb begin
        cnt_d = cnt_q;
        out_d = out_q;
        if (d.edge_p) begin
            // wrap also when the ratio shrinks below the count
            if (cnt_q >= d.ratio - 8'h01) begin
                cnt_d = `PLDM_COUNT_RST;
            end else begin
                cnt_d = cnt_q + 8'h01;
            end
            out_d = (cnt_d < (d.ratio >> 1));
        end
        // ratio one passes the input straight through
        if (d.ratio == 8'h01) begin
            out_d = d.level;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_q <= `PLDM_COUNT_RST;
            out_q <= 1'b0;
            rise_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            out_q <= out_d;
            rise_q <= out_d & ~out_q;
        end
    end

    assign d.clk_o = out_q;
    assign d.rise_p = rise_q;

    property p_cnt_in_range;
        @(posedge clk) disable iff (!rst_n)
        d.edge_p ##1 $stable(d.ratio) |-> cnt_q < d.ratio;
    endproperty
    a_cnt_in_range: assert property (p_cnt_in_range) else $error("divider count out of range");

    property p_bypass;
        @(posedge clk) disable iff (!rst_n)
        d.ratio == 8'h01 |=> out_q == $past(d.level);
    endproperty
    a_bypass: assert property (p_bypass) else $error("ratio one does not pass input");
endmodule
`default_nettype wire

/* pldm_top.sv */
// digital side of a phase-locked loop: dividers, phase detector, lock monitor
// assumes: crystal and oscillator clocks are pins below a quarter of CLK_IN
// Contract
// - reference clock is crystal divided by field plus one
// - feedback is oscillator divided by twice (field plus one)
// - output divides by twice field, one when zero
// - phase detector pulses follow reference/feedback phase
// - lock decided by comparing feedback and reference frequency
// - lock status is read-only
// - lock sets inside acquire, clears outside release tolerance
// - enabled interrupt raised on every lock toggle
`timescale 1ns/1ps
`default_nettype none
`include "pldm_regs.svh"
module pldm_top (
    input wire logic CLK_IN,
    input wire logic RST_N_IN,
    input wire logic CRYSTAL_CLOCK_IN,
    input wire logic CONTROLLED_OSCILLATOR_CLOCK_IN,
    input wire logic [5:0] REFERENCE_DIVIDE_FIELD_IN,
    input wire logic [5:0] FEEDBACK_DIVIDE_FIELD_IN,
    input wire logic [4:0] OUTPUT_DIVIDE_FIELD_IN,
    input wire logic [1:0] REFERENCE_RANGE_SELECT_IN,
    input wire logic [1:0] OSCILLATOR_RANGE_SELECT_IN,
    input wire logic LOCK_CHANGE_IRQ_ENABLE_IN,
    input wire logic LOCK_IRQ_ACK_IN,
    output logic DIVIDED_REFERENCE_CLOCK_OUT,
    output logic FEEDBACK_CLOCK_OUT,
    output logic LOOP_OUTPUT_CLOCK_OUT,
    output logic PUMP_UP_OUT,
    output logic PUMP_DOWN_OUT,
    output logic [3:0] LOOP_BANDWIDTH_OUT,
    output logic LOCK_OUT,
    output logic LOCK_PENDING_OUT,
    output logic LOCK_IRQ_OUT
);
    // ------------------------------------------------------------
    // pin synchronisers and edge detect
    // ------------------------------------------------------------
    logic xtal_s1_q, xtal_s2_q, xtal_s3_q;
    logic vco_s1_q, vco_s2_q, vco_s3_q;
    logic xtal_edge, vco_edge;

    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            xtal_s1_q <= 1'b0;
            xtal_s2_q <= 1'b0;
            xtal_s3_q <= 1'b0;
            vco_s1_q <= 1'b0;
            vco_s2_q <= 1'b0;
            vco_s3_q <= 1'b0;
        end else begin
            xtal_s1_q <= CRYSTAL_CLOCK_IN;
            xtal_s2_q <= xtal_s1_q;
            xtal_s3_q <= xtal_s2_q;
            vco_s1_q <= CONTROLLED_OSCILLATOR_CLOCK_IN;
            vco_s2_q <= vco_s1_q;
            vco_s3_q <= vco_s2_q;
        end
    end

    assign xtal_edge = xtal_s2_q & ~xtal_s3_q;
    assign vco_edge = vco_s2_q & ~vco_s3_q;

    // ------------------------------------------------------------
    // dividers
    // ------------------------------------------------------------
    pldm_div_if ref_if ();
    pldm_div_if fb_if ();
    pldm_div_if out_if ();

    assign ref_if.edge_p = xtal_edge;
    assign ref_if.level = xtal_s2_q;
    assign ref_if.ratio = {2'h0, REFERENCE_DIVIDE_FIELD_IN} + 8'h01;
    assign fb_if.edge_p = vco_edge;
    assign fb_if.level = vco_s2_q;
    // add outside the concatenation: a six-bit sum would wrap field 63 to ratio 0
    assign fb_if.ratio = {1'h0, FEEDBACK_DIVIDE_FIELD_IN, 1'h0} + 8'h02;
    assign out_if.edge_p = vco_edge;
    assign out_if.level = vco_s2_q;
    assign out_if.ratio = (OUTPUT_DIVIDE_FIELD_IN == 5'h00) ? `PLDM_RATIO_RST
                                                            : {2'h0, OUTPUT_DIVIDE_FIELD_IN, 1'h0};

    pldm_div u_ref_div (.clk(CLK_IN), .rst_n(RST_N_IN), .d(ref_if.div));
    pldm_div u_fb_div (.clk(CLK_IN), .rst_n(RST_N_IN), .d(fb_if.div));
    pldm_div u_out_div (.clk(CLK_IN), .rst_n(RST_N_IN), .d(out_if.div));

    logic ref_rise, fb_rise;
    assign ref_rise = ref_if.rise_p;
    assign fb_rise = fb_if.rise_p;

    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            DIVIDED_REFERENCE_CLOCK_OUT <= 1'b0;
            FEEDBACK_CLOCK_OUT <= 1'b0;
            LOOP_OUTPUT_CLOCK_OUT <= 1'b0;
        end else begin
            DIVIDED_REFERENCE_CLOCK_OUT <= ref_if.clk_o;
            FEEDBACK_CLOCK_OUT <= fb_if.clk_o;
            LOOP_OUTPUT_CLOCK_OUT <= out_if.clk_o;
        end
    end

    // ------------------------------------------------------------
    // range selects set the analog loop bandwidth
    // ------------------------------------------------------------
    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            LOOP_BANDWIDTH_OUT <= `PLDM_BW_RST;
        end else begin
            LOOP_BANDWIDTH_OUT <= {OSCILLATOR_RANGE_SELECT_IN, REFERENCE_RANGE_SELECT_IN};
        end
    end

    // ------------------------------------------------------------
    // phase detector: leading edge sets, second edge clears both
    // ------------------------------------------------------------
    logic up_d, dn_d;
    always_comb begin
        up_d = PUMP_UP_OUT | ref_rise;
        dn_d = PUMP_DOWN_OUT | fb_rise;
        if (up_d && dn_d) begin
            up_d = 1'b0;
            dn_d = 1'b0;
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            PUMP_UP_OUT <= 1'b0;
            PUMP_DOWN_OUT <= 1'b0;
        end else begin
            PUMP_UP_OUT <= up_d;
            PUMP_DOWN_OUT <= dn_d;
        end
    end

    // ------------------------------------------------------------
    // lock detector: feedback edges per window of reference edges
    // ------------------------------------------------------------
    logic [7:0] ref_cnt_q, fb_cnt_q, fb_total, fb_err;
    logic win_end;
    logic in_acquire, in_release;
    pldm_pkg::pldm_lock_e lock_q, lock_d;

    // decision rate scales with the reference clock
    assign win_end = ref_rise && (ref_cnt_q == `PLDM_LOCK_WINDOW - 8'h01);
    assign fb_total = fb_cnt_q + {7'h00, fb_rise};
    assign fb_err = (fb_total > `PLDM_LOCK_WINDOW) ? fb_total - `PLDM_LOCK_WINDOW
                                                   : `PLDM_LOCK_WINDOW - fb_total;
    assign in_acquire = fb_err <= `PLDM_ACQUIRE_TOL;
    assign in_release = fb_err <= `PLDM_RELEASE_TOL;

    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            ref_cnt_q <= `PLDM_COUNT_RST;
            fb_cnt_q <= `PLDM_COUNT_RST;
        end else if (win_end) begin
            ref_cnt_q <= `PLDM_COUNT_RST;
            fb_cnt_q <= `PLDM_COUNT_RST;
        end else begin
            ref_cnt_q <= ref_cnt_q + {7'h00, ref_rise};
            // saturate so a runaway oscillator cannot wrap into the window
            if (fb_cnt_q != 8'hFF) begin
                fb_cnt_q <= fb_total;
            end
        end
    end

    always_comb begin
        lock_d = lock_q;
        case (lock_q)
            pldm_pkg::PLDM_UNLOCKED: begin
                if (win_end && in_acquire) begin
                    lock_d = pldm_pkg::PLDM_LOCKED;
                end
            end
            pldm_pkg::PLDM_LOCKED: begin
                if (win_end && !in_release) begin
                    lock_d = pldm_pkg::PLDM_UNLOCKED;
                end
            end
            default: begin
                lock_d = pldm_pkg::PLDM_UNLOCKED;
            end
        endcase
    end

    // ------------------------------------------------------------
    // lock status and change request
    // ------------------------------------------------------------
    logic lock_chg, pend_d;
    assign lock_chg = (lock_d != lock_q);
    // a change in the acknowledge cycle wins over the clear
    assign pend_d = lock_chg | (LOCK_PENDING_OUT & ~LOCK_IRQ_ACK_IN);

    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            lock_q <= pldm_pkg::PLDM_UNLOCKED;
            LOCK_OUT <= 1'b0;
            LOCK_PENDING_OUT <= 1'b0;
            LOCK_IRQ_OUT <= 1'b0;
        end else begin
            lock_q <= lock_d;
            LOCK_OUT <= (lock_d == pldm_pkg::PLDM_LOCKED);
            LOCK_PENDING_OUT <= pend_d;
            LOCK_IRQ_OUT <= pend_d & LOCK_CHANGE_IRQ_ENABLE_IN;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_fb_even;
        @(posedge CLK_IN) disable iff (!RST_N_IN)
        fb_if.ratio[0] == 1'b0 && fb_if.ratio >= 8'h02 && fb_if.ratio <= 8'h80;
    endproperty
    a_fb_even: assert property (p_fb_even) else $error("feedback ratio not even in range");

    property p_pump_excl;
        @(posedge CLK_IN) disable iff (!RST_N_IN)
        !(PUMP_UP_OUT && PUMP_DOWN_OUT);
    endproperty
    a_pump_excl: assert property (p_pump_excl) else $error("both pump outputs active");

    property p_pump_up;
        @(posedge CLK_IN) disable iff (!RST_N_IN)
        ref_rise && !fb_rise && !PUMP_DOWN_OUT |=> PUMP_UP_OUT;
    endproperty
    a_pump_up: assert property (p_pump_up) else $error("reference lead gives no up pulse");

    property p_lock_at_window;
        @(posedge CLK_IN) disable iff (!RST_N_IN)
        !win_end |=> $stable(lock_q);
    endproperty
    a_lock_at_window: assert property (p_lock_at_window) else $error("lock moved off window");

    property p_hold_lock;
        @(posedge CLK_IN) disable iff (!RST_N_IN)
        lock_q == pldm_pkg::PLDM_LOCKED && in_release ##0 win_end |=> ##1 LOCK_OUT;
    endproperty
    a_hold_lock: assert property (p_hold_lock) else $error("lock lost inside release band");

    property p_pend_set;
        @(posedge CLK_IN) disable iff (!RST_N_IN)
        lock_chg |=> LOCK_PENDING_OUT && LOCK_OUT == (lock_q == pldm_pkg::PLDM_LOCKED);
    endproperty
    a_pend_set: assert property (p_pend_set) else $error("lock change not pending");

    property p_irq;
        @(posedge CLK_IN) disable iff (!RST_N_IN)
        lock_chg && LOCK_CHANGE_IRQ_ENABLE_IN |=> LOCK_IRQ_OUT;
    endproperty
    a_irq: assert property (p_irq) else $error("enabled lock change raised no request");

    property p_ack;
        @(posedge CLK_IN) disable iff (!RST_N_IN)
        LOCK_IRQ_ACK_IN && !lock_chg |=> !LOCK_PENDING_OUT && !LOCK_IRQ_OUT;
    endproperty
    a_ack: assert property (p_ack) else $error("acknowledge did not clear request");
endmodule
`default_nettype wire

/* pldm_top_test.sv */
// self-checking testbench of the loop divider and lock monitor, with a bench-side model
// assumes: pldm_pkg, pldm_regs.svh, pldm_div_if, pldm_div and pldm_top are compiled first
`timescale 1ns/1ps
`default_nettype none
module pldm_top_test;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic xtal = 1'b0;
    logic osc = 1'b0;
    logic [5:0] ref_fld = 6'h00;
    logic [5:0] fb_fld = 6'h00;
    logic [4:0] out_fld = 5'h00;
    logic [1:0] ref_rng = 2'h0;
    logic [1:0] osc_rng = 2'h0;
    logic irq_en = 1'b0;
    logic ack = 1'b0;
    logic ref_clk, fb_clk, out_clk, up, dn, lock, pend, irq;
    logic [3:0] bw;
    logic [31:0] rng_q = 32'h00009B56;
    logic exp_lock = 1'b0;
    logic exp_pend = 1'b0;
    int error_cnt = 0;
    int tests_run = 0;
    int cyc = 0;
    int xhalf = 4;
    int ohalf = 4;
    int xcnt = 0;
    int ocnt = 2;
    bit seen_up = 1'b0;
    bit seen_dn = 1'b0;

    pldm_top i_dut (
        .CLK_IN(clk), .RST_N_IN(rst_n),
        .CRYSTAL_CLOCK_IN(xtal), .CONTROLLED_OSCILLATOR_CLOCK_IN(osc),
        .REFERENCE_DIVIDE_FIELD_IN(ref_fld), .FEEDBACK_DIVIDE_FIELD_IN(fb_fld),
        .OUTPUT_DIVIDE_FIELD_IN(out_fld), .REFERENCE_RANGE_SELECT_IN(ref_rng),
        .OSCILLATOR_RANGE_SELECT_IN(osc_rng), .LOCK_CHANGE_IRQ_ENABLE_IN(irq_en),
        .LOCK_IRQ_ACK_IN(ack), .DIVIDED_REFERENCE_CLOCK_OUT(ref_clk),
        .FEEDBACK_CLOCK_OUT(fb_clk), .LOOP_OUTPUT_CLOCK_OUT(out_clk),
        .PUMP_UP_OUT(up), .PUMP_DOWN_OUT(dn), .LOOP_BANDWIDTH_OUT(bw),
        .LOCK_OUT(lock), .LOCK_PENDING_OUT(pend), .LOCK_IRQ_OUT(irq)
    );

    // ------------------------------------------------------------
    // clock, pin clocks and monitors
    // ------------------------------------------------------------
    initial begin
        forever #2 clk = ~clk;
    end

    // pin clocks are whole multiples of CLK so the edge counts are exact
    always @(negedge clk) begin
        xcnt <= (xcnt >= xhalf - 1) ? 0 : xcnt + 1;
        ocnt <= (ocnt >= ohalf - 1) ? 0 : ocnt + 1;
        if (xcnt >= xhalf - 1) xtal <= ~xtal;
        if (ocnt >= ohalf - 1) osc <= ~osc;
        if (rst_n && up === 1'b1) seen_up <= 1'b1;
        if (rst_n && dn === 1'b1) seen_dn <= 1'b1;
        if (rst_n && up === 1'b1 && dn === 1'b1) check(1, 0);
    end

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            error_cnt++;
            close_out();
        end
    end

    // ------------------------------------------------------------
    // helpers and model
    // ------------------------------------------------------------
    function automatic logic [31:0] rnd();
        rng_q = rng_q ^ (rng_q << 13);
        rng_q = rng_q ^ (rng_q >> 17);
        rng_q = rng_q ^ (rng_q << 5);
        return rng_q;
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    // cycles between the third and fourth rise; the first two let a new ratio settle
    task automatic period(input int sel, output int p);
        int n;
        int t3;
        int rises;
        logic prev;
        logic now;
        n = 0;
        t3 = 0;
        rises = 0;
        p = 0;
        prev = 1'b1;
        while (rises < 4 && n < 5000) begin
            @(negedge clk);
            n++;
            now = (sel == 0) ? ref_clk : (sel == 1) ? fb_clk : out_clk;
            if (now === 1'b1 && prev === 1'b0) begin
                rises++;
                if (rises == 3) t3 = n;
                if (rises == 4) p = n - t3;
            end
            prev = now;
        end
    endtask

    // feedback rises per window of 16 reference rises decide lock with hysteresis
    task automatic lock_case(input int xh, input int oh, input int rf, input int ff);
        int pref;
        int c;
        logic was;
        @(negedge clk);
        xhalf = xh;
        ohalf = oh;
        ref_fld = rf[5:0];
        fb_fld = ff[5:0];
        pref = 2 * xh * (rf + 1);
        c = (32 * xh * (rf + 1)) / (4 * oh * (ff + 1));
        repeat (48 * pref + 40) @(negedge clk);
        was = exp_lock;
        if (!exp_lock && c >= 15 && c <= 17) exp_lock = 1'b1;
        else if (exp_lock && (c < 13 || c > 19)) exp_lock = 1'b0;
        if (was != exp_lock) exp_pend = 1'b1;
        check(lock, exp_lock);
        check(pend, exp_pend);
        check(irq, exp_pend & irq_en);
    endtask

    task automatic do_ack();
        @(negedge clk);
        ack = 1'b1;
        @(negedge clk);
        ack = 1'b0;
        @(negedge clk);
        exp_pend = 1'b0;
        check(pend, 1'b0);
        check(irq, 1'b0);
    endtask

    task automatic close_out();
        $display("comparisons %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        int p;
        logic [31:0] r;
        repeat (3) @(negedge clk);
        check({ref_clk, fb_clk, out_clk, up, dn, bw, lock, pend, irq}, 0);
        rst_n = 1'b1;
        // boundary ratios first, then random ones
        for (int i = 0; i < 5; i++) begin
            r = rnd();
            @(negedge clk);
            ref_fld = (i == 0) ? 6'h3F : (i == 1) ? 6'h00 : {3'h0, r[2:0]};
            fb_fld = (i == 0) ? 6'h3F : (i == 1) ? 6'h00 : {4'h0, r[4:3]};
            out_fld = (i == 0) ? 5'h1F : (i == 1) ? 5'h00 : {2'h0, r[7:5]};
            period(0, p);
            check(p, 8 * (ref_fld + 1));
            period(1, p);
            check(p, 16 * (fb_fld + 1));
            period(2, p);
            check(p, 8 * ((out_fld == 5'h00) ? 1 : 2 * out_fld));
        end
        for (int i = 0; i < 4; i++) begin
            r = rnd();
            @(negedge clk);
            ref_rng = i[1:0];
            osc_rng = r[1:0];
            @(negedge clk);
            check(bw, {osc_rng, ref_rng});
        end
        irq_en = 1'b1;
        lock_case(4, 4, 1, 0);
        do_ack();
        // loop output taken into use only once lock reads set
        check(lock, 1'b1);
        period(2, p);
        check(p, 8 * ((out_fld == 5'h00) ? 1 : 2 * out_fld));
        lock_case(37, 16, 0, 0);
        lock_case(4, 4, 0, 0);
        check(lock, 1'b0);
        do_ack();
        irq_en = 1'b0;
        lock_case(27, 16, 0, 0);
        lock_case(4, 4, 1, 0);
        @(negedge clk);
        irq_en = 1'b1;
        @(negedge clk);
        check(irq, 1'b1);
        check({seen_up, seen_dn}, 2'b11);
        close_out();
    end
endmodule
`default_nettype wire
